// ===== dac_trim_device.sv
// Device end: serial frame receiver and per-channel gain and offset trim registers
`timescale 1ns/100ps
`include "dac_trim_defines.svh"

// Functional notes
// - Select 010 writes gain of one channel
// - Channel field picks the target channel
// - Select 011 writes gain to all channels
// - Gain 16 bits, or 12 upper bits
// - Host sets low four gain bits high
// - Gain is unsigned straight binary
// - Host should keep gain trim moderate
// - Select 100 writes offset of one channel
// - Select 101 writes offset to all channels
// - Offset 16 or 12 bits, signed range
// - Short variant drops low four offset bits
// - Offset resets to midscale, zero offset
// - Channel codes 0..3 map to A..D
// - Act only when part address matches straps
module dac_trim_device #(
   parameter int RESOLUTION = `FULL_RESOLUTION
)
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   dac_link_if.device link,
   input wire logic i_part_strap_pin1,
   input wire logic i_part_strap_pin0,
   output dac_trim_pkg::trim_array_type o_gain_trim,
   output dac_trim_pkg::trim_array_type o_offset_trim,
   output logic o_frame_accepted,
   output logic o_frame_ignored
);
   import dac_trim_pkg::*;

   // --------------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------------
   rx_state_type rx_state;
   rx_state_type next_rx_state;
   logic [`FRAME_BITS-1:0] shift_reg;
   logic [`FRAME_BITS-1:0] next_shift_reg;
   logic [4:0] bit_count;
   logic [4:0] next_bit_count;
   logic sclk_prev;
   logic sclk_rise;
   logic frame_end;
   logic frame_complete;
   logic addressed;
   logic is_write;
   part_address_type part_field;
   reg_select_type select_field;
   channel_select_type channel_field;
   trim_type data_field;
   logic [`CHANNELS-1:0] gain_hit;
   logic [`CHANNELS-1:0] offset_hit;
   trim_array_type gain_trim;
   trim_array_type next_gain_trim;
   trim_array_type offset_trim;
   trim_array_type next_offset_trim;
   logic next_frame_accepted;
   logic next_frame_ignored;

   // --------------------------------------------------------------------------
   // Stored trim value for the active variant
   // --------------------------------------------------------------------------
   // The short variant keeps only the upper bits; the low nibble is forced
   // so that what is stored never depends on what the host left there.
   function automatic trim_type trim_value
   (
      input trim_type data,
      input logic is_gain
   );
      trim_type result;
      result = data;
      if (RESOLUTION == `SHORT_RESOLUTION)
      begin
         if (is_gain)
         begin
            result[`UNUSED_LOW_BITS-1:0] = `GAIN_LOW_FILL;
         end
         else
         begin
            result[`UNUSED_LOW_BITS-1:0] = `OFFSET_LOW_FILL;
         end
      end
      return result;
   endfunction

   // --------------------------------------------------------------------------
   // Frame receiver
   // --------------------------------------------------------------------------
   assign sclk_rise = link.sclk & ~sclk_prev;
   assign frame_end = (rx_state != rx_idle_state) & link.sync_n;
   assign frame_complete = (rx_state == rx_shift_state) && (bit_count == `FRAME_COUNT_FULL);

   always_comb
   begin
      next_rx_state = rx_state;
      next_shift_reg = shift_reg;
      next_bit_count = bit_count;
      case (rx_state)
         rx_idle_state:
         begin
            if (!link.sync_n)
            begin
               next_rx_state = rx_shift_state;
               next_bit_count = 5'h00;
            end
         end
         rx_shift_state:
         begin
            if (link.sync_n)
            begin
               next_rx_state = rx_idle_state;
            end
            else if (sclk_rise)
            begin
               // Clocks beyond the frame length spoil the frame
               if (bit_count == `FRAME_COUNT_FULL)
               begin
                  next_rx_state = rx_overrun_state;
               end
               else
               begin
                  next_shift_reg = {shift_reg[`FRAME_BITS-2:0], link.sdin};
                  next_bit_count = bit_count + 5'h01;
               end
            end
         end
         rx_overrun_state:
         begin
            if (link.sync_n)
            begin
               next_rx_state = rx_idle_state;
            end
         end
         default:
         begin
            next_rx_state = rx_idle_state;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_state <= rx_idle_state;
         shift_reg <= '0;
         bit_count <= 5'h00;
         sclk_prev <= 1'b0;
      end
      else
      begin
         rx_state <= next_rx_state;
         shift_reg <= next_shift_reg;
         bit_count <= next_bit_count;
         sclk_prev <= link.sclk;
      end
   end

   // --------------------------------------------------------------------------
   // Frame decode
   // --------------------------------------------------------------------------
   assign is_write = (shift_reg[`RW_POS] == `RW_WRITE);
   assign part_field = shift_reg[`PART_HI:`PART_LO];
   assign select_field = shift_reg[`REG_SELECT_HI:`REG_SELECT_LO];
   assign channel_field = shift_reg[`CHANNEL_HI:`CHANNEL_LO];
   assign data_field = shift_reg[`DATA_HI:`DATA_LO];
   assign addressed = frame_end & frame_complete & is_write
      & (part_field == {i_part_strap_pin1, i_part_strap_pin0});

   // Channel index equals the channel code, so 0..3 reach A..D
   for (genvar ch = 0; ch < `CHANNELS; ch++)
   begin : channel_decode
      assign gain_hit[ch] = addressed & ((select_field == `SELECT_GAIN_ALL)
         | ((select_field == `SELECT_GAIN_ONE) & (channel_field == 2'(ch))));
      assign offset_hit[ch] = addressed & ((select_field == `SELECT_OFFSET_ALL)
         | ((select_field == `SELECT_OFFSET_ONE) & (channel_field == 2'(ch))));
   end

   // --------------------------------------------------------------------------
   // Trim registers
   // --------------------------------------------------------------------------
   // Gain is kept as an unsigned code; offset is straight binary with
   // midscale meaning no shift, so the downstream math subtracts midscale.
   always_comb
   begin
      next_gain_trim = gain_trim;
      next_offset_trim = offset_trim;
      for (int ch = 0; ch < `CHANNELS; ch++)
      begin
         if (gain_hit[ch])
         begin
            next_gain_trim[ch] = trim_value(data_field, 1'b1);
         end
         if (offset_hit[ch])
         begin
            next_offset_trim[ch] = trim_value(data_field, 1'b0);
         end
      end
      next_frame_accepted = |{gain_hit, offset_hit};
      next_frame_ignored = frame_end & ~(|{gain_hit, offset_hit});
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int ch = 0; ch < `CHANNELS; ch++)
         begin
            gain_trim[ch] <= `GAIN_RESET;
            offset_trim[ch] <= `OFFSET_RESET;
         end
         o_frame_accepted <= 1'b0;
         o_frame_ignored <= 1'b0;
      end
      else
      begin
         gain_trim <= next_gain_trim;
         offset_trim <= next_offset_trim;
         o_frame_accepted <= next_frame_accepted;
         o_frame_ignored <= next_frame_ignored;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   assign o_gain_trim = gain_trim;
   assign o_offset_trim = offset_trim;
endmodule

// ===== dac_trim_defines.svh
// Frame layout, register-select codes, reset values and timing counts for the trim link
`ifndef DAC_TRIM_DEFINES_SVH
`define DAC_TRIM_DEFINES_SVH

// --------------------------------------------------------------------------
// Frame layout
// --------------------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_COUNT_LAST 5'h17
`define FRAME_COUNT_FULL 5'h18
`define RW_POS 23
`define RW_WRITE 1'b0
`define PART_HI 22
`define PART_LO 21
`define REG_SELECT_HI 20
`define REG_SELECT_LO 18
`define CHANNEL_HI 17
`define CHANNEL_LO 16
`define DATA_HI 15
`define DATA_LO 0

// --------------------------------------------------------------------------
// Register-select codes
// --------------------------------------------------------------------------
`define SELECT_GAIN_ONE 3'h2
`define SELECT_GAIN_ALL 3'h3
`define SELECT_OFFSET_ONE 3'h4
`define SELECT_OFFSET_ALL 3'h5

// --------------------------------------------------------------------------
// Variants and reset values
// --------------------------------------------------------------------------
`define FULL_RESOLUTION 16
`define SHORT_RESOLUTION 12
`define UNUSED_LOW_BITS 4
`define GAIN_LOW_FILL 4'hf
`define OFFSET_LOW_FILL 4'h0
`define GAIN_RESET 16'h0000
`define OFFSET_RESET 16'h8000
`define CHANNELS 4

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define SCLK_HALF_CYCLES 4

`endif

// ===== dac_trim_pkg.sv
// Types shared by both ends of the trim link
`include "dac_trim_defines.svh"

package dac_trim_pkg;
   typedef logic [15:0] trim_type;
   typedef logic [`CHANNELS-1:0][15:0] trim_array_type;
   typedef logic [2:0] reg_select_type;
   typedef logic [1:0] channel_select_type;
   typedef logic [1:0] part_address_type;

   // --------------------------------------------------------------------------
   // State machines
   // --------------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      rx_idle_state = 3'h1,
      rx_shift_state = 3'h2,
      rx_overrun_state = 3'h4
   } rx_state_type;

   typedef enum logic [3:0]
   {
      tx_idle_state = 4'h1,
      tx_lead_state = 4'h2,
      tx_shift_state = 4'h4,
      tx_trail_state = 4'h8
   } tx_state_type;
endpackage

// ===== dac_link_if.sv
// Serial write link between the host controller and the trim register bank
`timescale 1ns/100ps

interface dac_link_if;
   logic sclk;
   logic sync_n;
   logic sdin;

   modport host
   (
      output sclk,
      output sync_n,
      output sdin
   );

   modport device
   (
      input sclk,
      input sync_n,
      input sdin
   );
endinterface

// ===== dac_trim_host.sv
// Host end: builds and shifts out 24-bit trim write frames
`timescale 1ns/100ps
`include "dac_trim_defines.svh"

module dac_trim_host #(
   parameter int RESOLUTION = `FULL_RESOLUTION,
   parameter int SCLK_HALF_CYCLES = `SCLK_HALF_CYCLES
)
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   dac_link_if.host link,
   input wire logic i_write_valid,
   input dac_trim_pkg::part_address_type i_part_address,
   input dac_trim_pkg::reg_select_type i_reg_select,
   input dac_trim_pkg::channel_select_type i_channel_select,
   input dac_trim_pkg::trim_type i_data,
   output logic o_ready,
   output logic o_done
);
   import dac_trim_pkg::*;

   // --------------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------------
   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYCLES - 1);
   tx_state_type tx_state;
   tx_state_type next_tx_state;
   logic [7:0] div_count;
   logic [7:0] next_div_count;
   logic tick;
   logic [`FRAME_BITS-1:0] frame;
   logic [`FRAME_BITS-1:0] next_frame;
   logic [4:0] bit_count;
   logic [4:0] next_bit_count;
   logic sclk;
   logic next_sclk;
   logic sync_n;
   logic next_sync_n;
   logic sdin;
   logic next_sdin;
   logic next_ready;
   logic next_done;
   logic [`FRAME_BITS-1:0] built;

   // --------------------------------------------------------------------------
   // Frame builder
   // --------------------------------------------------------------------------
   // The short variant expects fixed low bits; forcing them here means
   // callers can pass any data without caring which part is fitted.
   function automatic logic [`FRAME_BITS-1:0] build_frame
   (
      input part_address_type part,
      input reg_select_type select,
      input channel_select_type channel,
      input trim_type data
   );
      trim_type word;
      word = data;
      if (RESOLUTION == `SHORT_RESOLUTION)
      begin
         if ((select == `SELECT_GAIN_ONE) || (select == `SELECT_GAIN_ALL))
         begin
            word[`UNUSED_LOW_BITS-1:0] = `GAIN_LOW_FILL;
         end
         else if ((select == `SELECT_OFFSET_ONE) || (select == `SELECT_OFFSET_ALL))
         begin
            word[`UNUSED_LOW_BITS-1:0] = `OFFSET_LOW_FILL;
         end
      end
      return {`RW_WRITE, part, select, channel, word};
   endfunction

   assign built = build_frame(i_part_address, i_reg_select, i_channel_select, i_data);

   // --------------------------------------------------------------------------
   // Serial clock divider and shifter
   // --------------------------------------------------------------------------
   assign tick = (div_count == HALF_LAST);

   always_comb
   begin
      next_tx_state = tx_state;
      next_div_count = (tx_state == tx_idle_state || tick) ? 8'h00 : div_count + 8'h01;
      next_frame = frame;
      next_bit_count = bit_count;
      next_sclk = sclk;
      next_sync_n = sync_n;
      next_sdin = sdin;
      next_ready = o_ready;
      next_done = 1'b0;
      case (tx_state)
         tx_idle_state:
         begin
            if (i_write_valid)
            begin
               next_frame = built;
               next_sdin = built[`FRAME_BITS-1];
               next_sync_n = 1'b0;
               next_ready = 1'b0;
               next_bit_count = 5'h00;
               next_tx_state = tx_lead_state;
            end
         end
         tx_lead_state:
         begin
            if (tick)
            begin
               next_sclk = 1'b1;
               next_tx_state = tx_shift_state;
            end
         end
         tx_shift_state:
         begin
            if (tick)
            begin
               if (sclk)
               begin
                  next_sclk = 1'b0;
                  next_bit_count = bit_count + 5'h01;
                  if (bit_count == `FRAME_COUNT_LAST)
                  begin
                     next_tx_state = tx_trail_state;
                  end
                  else
                  begin
                     // MSB first: the next bit is set up while the clock is low
                     next_frame = {frame[`FRAME_BITS-2:0], 1'b0};
                     next_sdin = frame[`FRAME_BITS-2];
                  end
               end
               else
               begin
                  next_sclk = 1'b1;
               end
            end
         end
         tx_trail_state:
         begin
            if (tick)
            begin
               next_sync_n = 1'b1;
               next_done = 1'b1;
               next_ready = 1'b1;
               next_tx_state = tx_idle_state;
            end
         end
         default:
         begin
            next_tx_state = tx_idle_state;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tx_state <= tx_idle_state;
         div_count <= 8'h00;
         frame <= '0;
         bit_count <= 5'h00;
         sclk <= 1'b0;
         sync_n <= 1'b1;
         sdin <= 1'b0;
         o_ready <= 1'b1;
         o_done <= 1'b0;
      end
      else
      begin
         tx_state <= next_tx_state;
         div_count <= next_div_count;
         frame <= next_frame;
         bit_count <= next_bit_count;
         sclk <= next_sclk;
         sync_n <= next_sync_n;
         sdin <= next_sdin;
         o_ready <= next_ready;
         o_done <= next_done;
      end
   end

   assign link.sclk = sclk;
   assign link.sync_n = sync_n;
   assign link.sdin = sdin;
endmodule

// ===== dac_trim_link_chk.sv
// Assertions on the serial trim link between host and device
`timescale 1ns/100ps

module dac_trim_link_chk
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdin
);
   logic sclk_last;
   logic next_sclk_last;
   logic [4:0] rise_count;
   logic [4:0] next_rise_count;

   // ------
   // Rising serial edges seen in the open frame
   // ------
   always_comb
   begin
      next_sclk_last = sclk;
      next_rise_count = sync_n ? 5'h00 : rise_count + {4'h0, sclk & ~sclk_last};
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sclk_last <= 1'b0;
         rise_count <= 5'h00;
      end
      else
      begin
         sclk_last <= next_sclk_last;
         rise_count <= next_rise_count;
      end
   end

   // ------
   // Link checks
   // ------
   default clocking link_cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   a_idle_clock_low: assert property (sync_n |-> !sclk)
      else $error("serial clock high outside a frame");
   a_frame_bit_count: assert property ($rose(sync_n) |-> rise_count == 5'h18)
      else $error("frame closed without exactly 24 bits");
   a_write_flag_clear: assert property ((!sync_n && rise_count == 5'h00 && sclk && !sclk_last) |-> !sdin)
      else $error("first frame bit is not a write flag");
   a_data_held_high: assert property ((sclk && !sync_n) |-> $stable(sdin))
      else $error("serial data moved while clock high");
   a_frame_ends_bounded: assert property ($fell(sync_n) |-> ##[1:1000] $rose(sync_n))
      else $error("frame never closed");
   a_clock_low_at_end: assert property ($rose(sync_n) |-> !sclk && !sclk_last)
      else $error("frame closed with clock high");
   a_gap_after_frame: assert property ($rose(sync_n) |=> !sclk)
      else $error("serial clock rose right after frame close");
   a_first_edge_soon: assert property ($fell(sync_n) |-> !sclk ##[1:8] $rose(sclk))
      else $error("frame opened without a prompt first edge");
endmodule

// ===== tb_top.sv
// Bench: a full pair, a short device fed by a full-width host, and a short host feeding a full device
`timescale 1ns/100ps
`include "dac_trim_defines.svh"

module tb_top;
   import dac_trim_pkg::*;
   typedef struct
   {
      logic ok;
      trim_array_type gain [2];
      trim_array_type offset [2];
   } note_type;

   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic write_valid = 1'b0;
   part_address_type part = 2'h0;
   reg_select_type select = 3'h0;
   channel_select_type channel = 2'h0;
   trim_type data = 16'h0000;
   logic [1:0] strap = 2'h2;
   logic [2:0] ready;
   logic [2:0] done;
   logic [2:0] done_last = 3'h0;
   logic [2:0] accepted;
   logic [2:0] ignored;
   trim_array_type gain [3];
   trim_array_type offset [3];
   trim_array_type model_gain [2];
   trim_array_type model_offset [2];
   note_type notes [$];
   int fail_count = 0;
   int cmp_count = 0;

   dac_link_if dac_link_if_i ();
   dac_link_if dac_link_if_i2 ();
   dac_link_if dac_link_if_i3 ();

   dac_trim_host #(.RESOLUTION(`FULL_RESOLUTION), .SCLK_HALF_CYCLES(1)) dac_trim_host_i
   (.i_clock, .i_reset_n, .link(dac_link_if_i.host), .i_write_valid(write_valid), .i_part_address(part),
    .i_reg_select(select), .i_channel_select(channel), .i_data(data), .o_ready(ready[0]), .o_done(done[0]));
   dac_trim_device #(.RESOLUTION(`FULL_RESOLUTION)) dac_trim_device_i
   (.i_clock, .i_reset_n, .link(dac_link_if_i.device), .i_part_strap_pin1(strap[1]), .i_part_strap_pin0(strap[0]),
    .o_gain_trim(gain[0]), .o_offset_trim(offset[0]), .o_frame_accepted(accepted[0]), .o_frame_ignored(ignored[0]));
   // Full-width host leaves the low nibble as given, so the short device must fix it itself
   dac_trim_host #(.RESOLUTION(`FULL_RESOLUTION), .SCLK_HALF_CYCLES(1)) dac_trim_host_i2
   (.i_clock, .i_reset_n, .link(dac_link_if_i2.host), .i_write_valid(write_valid), .i_part_address(part),
    .i_reg_select(select), .i_channel_select(channel), .i_data(data), .o_ready(ready[1]), .o_done(done[1]));
   dac_trim_device #(.RESOLUTION(`SHORT_RESOLUTION)) dac_trim_device_i2
   (.i_clock, .i_reset_n, .link(dac_link_if_i2.device), .i_part_strap_pin1(strap[1]), .i_part_strap_pin0(strap[0]),
    .o_gain_trim(gain[1]), .o_offset_trim(offset[1]), .o_frame_accepted(accepted[1]), .o_frame_ignored(ignored[1]));
   // Short host must fill the low nibble itself, so a full device stores exactly what it sends
   dac_trim_host #(.RESOLUTION(`SHORT_RESOLUTION), .SCLK_HALF_CYCLES(1)) dac_trim_host_i3
   (.i_clock, .i_reset_n, .link(dac_link_if_i3.host), .i_write_valid(write_valid), .i_part_address(part),
    .i_reg_select(select), .i_channel_select(channel), .i_data(data), .o_ready(ready[2]), .o_done(done[2]));
   dac_trim_device #(.RESOLUTION(`FULL_RESOLUTION)) dac_trim_device_i3
   (.i_clock, .i_reset_n, .link(dac_link_if_i3.device), .i_part_strap_pin1(strap[1]), .i_part_strap_pin0(strap[0]),
    .o_gain_trim(gain[2]), .o_offset_trim(offset[2]), .o_frame_accepted(accepted[2]), .o_frame_ignored(ignored[2]));
   dac_trim_link_chk dac_trim_link_chk_i
   (.i_clock, .i_reset_n, .sclk(dac_link_if_i.sclk), .sync_n(dac_link_if_i.sync_n), .sdin(dac_link_if_i.sdin));

   always #4 i_clock = ~i_clock;

   // ------
   // Tasks
   // ------
   task automatic check(input logic good, input string what);
      cmp_count++;
      if (good !== 1'b1)
      begin
         fail_count++;
         $display("unexpected at %0t ns: %s", $time, what);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic compare_trims(input note_type n);
      check(gain[0] === n.gain[0], "gain trims");
      check(offset[0] === n.offset[0], "offset trims");
      check(gain[1] === n.gain[1], "short gain trims");
      check(offset[1] === n.offset[1], "short offset trims");
      check(gain[2] === n.gain[1], "short host gain fill");
      check(offset[2] === n.offset[1], "short host offset fill");
   endtask

   task automatic check_defaults();
      note_type n;
      for (int i = 0; i < 2; i++)
      begin
         model_gain[i] = {4{16'h0000}};
         model_offset[i] = {4{16'h8000}};
      end
      n.gain = model_gain;
      n.offset = model_offset;
      compare_trims(n);
   endtask

   // Bounded wait for all three hosts idle, and optionally for every result to be seen
   task automatic wait_idle(input bit drain);
      int k;
      k = 0;
      while (ready !== 3'h7 || (drain && notes.size() != 0))
      begin
         @(negedge i_clock);
         k++;
         if (k > 500)
         begin
            check(1'b0, "link stalled");
            end_of_test();
         end
      end
   endtask

   task automatic send(input part_address_type p, input reg_select_type s, input channel_select_type c,
      input trim_type d);
      note_type n;
      wait_idle(1'b0);
      n.ok = p === strap && s inside {3'h2, 3'h3, 3'h4, 3'h5};
      for (int i = 0; i < 4; i++)
      begin
         if (n.ok && (s[0] || c == i) && s[2])
         begin
            model_offset[0][i] = d;
            model_offset[1][i] = {d[15:4], 4'h0};
         end
         if (n.ok && (s[0] || c == i) && !s[2])
         begin
            model_gain[0][i] = d;
            model_gain[1][i] = {d[15:4], 4'hf};
         end
      end
      n.gain = model_gain;
      n.offset = model_offset;
      notes.push_back(n);
      part = p;
      select = s;
      channel = c;
      data = d;
      write_valid = 1'b1;
      @(negedge i_clock);
      write_valid = 1'b0;
   endtask

   // ------
   // Result monitor
   // ------
   always @(negedge i_clock)
   begin
      note_type n;
      if (accepted[0] === 1'b1 || ignored[0] === 1'b1)
      begin
         if (notes.size() == 0)
            check(1'b0, "result with no request");
         else
         begin
            n = notes.pop_front();
            check(accepted === {3{n.ok}}, "accept flags");
            check(ignored === {3{!n.ok}}, "ignore flags");
            // Host done pulses one cycle, on the edge before the device judges the frame
            check(done_last === 3'h7 && done === 3'h0, "host done pulse");
            compare_trims(n);
         end
      end
      done_last = done;
   end

   initial
   begin
      void'($urandom(32'h01ea_d8ed));
      repeat (20) @(negedge i_clock);
      i_reset_n = 1'b1;
      check_defaults();
      $display("test reset_defaults done");
      for (int s = 0; s < 8; s++)
         for (int c = 0; c < 4; c++)
            send(strap, 3'(s), 2'(c), c == 0 ? 16'h0000 : c == 3 ? 16'hffff : 16'($urandom));
      $display("test select_codes done");
      for (int k = 0; k < 24; k++)
      begin
         // Straps are compared live, so they only move once the last frame is judged
         wait_idle(1'b1);
         strap = 2'($urandom);
         send(2'($urandom), 3'(2 + $urandom % 4), 2'($urandom), 16'($urandom));
      end
      wait_idle(1'b1);
      $display("test part_address done");
      send(strap, 3'h5, 2'h0, 16'h1234);
      repeat (20) @(negedge i_clock);
      i_reset_n = 1'b0;
      notes.delete();
      repeat (3) @(negedge i_clock);
      i_reset_n = 1'b1;
      check_defaults();
      send(strap, 3'h3, 2'h1, 16'h00ff);
      wait_idle(1'b1);
      $display("test reset_mid_frame done");
      end_of_test();
   end
endmodule
